// >>> pressure_fifo_pkg.sv
package pressure_fifo_pkg;
  localparam int DEPTH       = 32;
  localparam int SAMPLE_W    = 24;
  localparam int PTR_W       = 5;
  localparam int CNT_W       = 6;
  localparam int SUM_W       = 29;
  localparam int STAGE_DEPTH = 8;
  localparam int TRIM_WORDS  = 4;
  localparam int DEC_W       = 5;

  localparam logic [6:0] ADDR_CONTROL_TWO  = 7'h21;
  localparam logic [6:0] ADDR_CONTROL_FOUR = 7'h23;
  localparam logic [6:0] ADDR_INT_CONFIG   = 7'h24;
  localparam logic [6:0] ADDR_INT_SOURCE   = 7'h25;
  localparam logic [6:0] ADDR_OUT_LOWEST   = 7'h28;
  localparam logic [6:0] ADDR_OUT_MIDDLE   = 7'h29;
  localparam logic [6:0] ADDR_OUT_UPPER    = 7'h2A;
  localparam logic [6:0] ADDR_BUFFER_CFG   = 7'h2E;
  localparam logic [6:0] ADDR_BUFFER_STATE = 7'h2F;

  localparam int C2_ENABLE_BIT   = 6;
  localparam int C2_LIMIT_BIT    = 5;
  localparam int C2_DECIMATE_BIT = 4;
  localparam int IC_LATCH_BIT    = 2;
  localparam int IS_ACTIVE_BIT   = 2;
  localparam int C4_DRDY_BIT     = 0;
  localparam int C4_OVR_BIT      = 1;
  localparam int C4_WTM_BIT      = 2;
  localparam int C4_EMPTY_BIT    = 3;
  localparam int BC_MODE_LSB     = 5;
  localparam int ST_WTM_BIT      = 7;
  localparam int ST_OVR_BIT      = 6;

  localparam logic [2:0] RATE_7HZ  = 3'h2;
  localparam logic [2:0] RATE_12HZ = 3'h3;
  localparam logic [2:0] RATE_25HZ = 3'h4;
  localparam logic [DEC_W-1:0] DIV_7HZ  = 5'h07;
  localparam logic [DEC_W-1:0] DIV_12HZ = 5'h0C;
  localparam logic [DEC_W-1:0] DIV_25HZ = 5'h19;
  localparam logic [DEC_W-1:0] DIV_NONE = 5'h01;

  typedef enum logic [2:0] {
    MODE_BYPASS        = 3'h0,
    MODE_FILL          = 3'h1,
    MODE_STREAM        = 3'h2,
    MODE_STREAM_FILL   = 3'h3,
    MODE_BYPASS_STREAM = 3'h4,
    MODE_MEAN          = 3'h6,
    MODE_BYPASS_FILL   = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    BEH_IDLE,
    BEH_FILL,
    BEH_STREAM,
    BEH_MEAN
  } behav_t;
endpackage

// >>> pressure_sample_fifo.sv
`timescale 1ns/1ns
module stage_fifo
  import pressure_fifo_pkg::*;
#(
  parameter int W = 24,
  parameter int D = 8
)
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd;
    logic [AW-1:0]       wr;
    logic [AW:0]         count;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t s;
  logic        push;
  logic        pop;

  assign in_ready  = (q.count != (AW+1)'(D));
  assign out_valid = (q.count != '0);
  assign out_data  = q.mem[q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s = q;
    if (push)
    begin
      s.mem[q.wr] = in_data;
      s.wr        = q.wr + 1'b1;
    end
    if (pop)
      s.rd = q.rd + 1'b1;
    s.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else if (ce)
      q <= s;
  end
endmodule

module pressure_sample_fifo
  import pressure_fifo_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  CE,
  input  wire logic                  SAMPLE_VALID,
  output logic                       SAMPLE_READY,
  input  wire logic [SAMPLE_W-1:0]   SAMPLE_DATA,
  input  wire logic [2:0]            SAMPLE_RATE,
  input  wire logic                  TRIGGER_EVENT,
  input  wire logic                  REG_START,
  input  wire logic [6:0]            REG_ADDR,
  input  wire logic                  REG_AUTO_INC,
  input  wire logic                  REG_WR,
  input  wire logic [7:0]            REG_WDATA,
  input  wire logic                  REG_RD,
  output logic [7:0]                 REG_RDATA,
  output logic [1:0]                 NVM_ADDR,
  input  wire logic [7:0]            NVM_DATA,
  output logic                       TRIM_DONE,
  output logic [8*TRIM_WORDS-1:0]    TRIM_VALUE,
  output logic                       DATA_READY,
  output logic                       INTERRUPT_READY_PIN
);
  typedef struct packed {
    logic [DEPTH-1:0][SAMPLE_W-1:0] mem;
    logic [PTR_W-1:0]               rd;
    logic [PTR_W-1:0]               wr;
    logic [CNT_W-1:0]               count;
    logic signed [SUM_W-1:0]        sum;
    logic [DEC_W-1:0]               dec_cnt;
    logic [SAMPLE_W-1:0]            out;
    logic [7:0]                     c2;
    logic [7:0]                     c4;
    logic [7:0]                     icfg;
    logic [7:0]                     bcfg;
    logic [7:0]                     rdata;
    logic [6:0]                     ptr;
    logic                           inc;
    logic                           ia;
    logic                           trig;
    logic                           ovr;
    logic                           drdy;
    logic                           trim_done;
    logic [1:0]                     trim_idx;
    logic [TRIM_WORDS-1:0][7:0]     trim;
  } state_t;

  function automatic behav_t behaviour(input logic en, input logic [2:0] m, input logic tr);
    behav_t b;
    b = BEH_IDLE;
    if (en)
    begin
      unique case (mode_t'(m))
        MODE_BYPASS:        b = BEH_IDLE;
        MODE_FILL:          b = BEH_FILL;
        MODE_STREAM:        b = BEH_STREAM;
        MODE_STREAM_FILL:   b = tr ? BEH_FILL : BEH_STREAM;
        MODE_BYPASS_STREAM: b = tr ? BEH_STREAM : BEH_IDLE;
        MODE_BYPASS_FILL:   b = tr ? BEH_FILL : BEH_IDLE;
        MODE_MEAN:          b = BEH_MEAN;
        default:            b = BEH_IDLE;
      endcase
    end
    return b;
  endfunction

  function automatic logic [2:0] window_shift(input logic [4:0] w);
    logic [2:0] sh;
    sh = 3'h0;
    for (int i = 0; i < 5; i++)
      if (w[i])
        sh = 3'(i + 1);
    return sh;
  endfunction

  function automatic logic [DEC_W-1:0] rate_divider(input logic [2:0] r);
    logic [DEC_W-1:0] v;
    unique case (r)
      RATE_7HZ:  v = DIV_7HZ;
      RATE_12HZ: v = DIV_12HZ;
      RATE_25HZ: v = DIV_25HZ;
      default:   v = DIV_NONE;
    endcase
    return v;
  endfunction

  function automatic logic [6:0] next_addr(input logic [6:0] a);
    return (a == ADDR_OUT_UPPER) ? ADDR_OUT_LOWEST : a + 7'h01;
  endfunction

  state_t                  q;
  state_t                  s;
  behav_t                  beh;
  logic [SAMPLE_W-1:0]     stage_data;
  logic                    stage_valid;
  logic                    stage_ready;
  logic                    stage_in_ready;
  logic                    take;
  logic                    pop_read;
  logic                    cfg_write;
  logic                    buffered;
  logic                    full;
  logic                    wtm_flag;
  logic [CNT_W-1:0]        eff_depth;
  logic [CNT_W-1:0]        win;
  logic [CNT_W-1:0]        cnt;
  logic [SAMPLE_W-1:0]     shown;
  logic [4:0]              wtm;
  logic signed [SUM_W-1:0] new_ext;
  logic signed [SUM_W-1:0] old_ext;

  assign wtm       = q.bcfg[4:0];
  assign cnt       = q.count;
  assign beh       = behaviour(q.c2[C2_ENABLE_BIT], q.bcfg[7:BC_MODE_LSB], q.trig);
  assign buffered  = (beh == BEH_FILL) || (beh == BEH_STREAM);
  assign win       = CNT_W'(wtm) + 6'h01;
  assign eff_depth = (beh == BEH_MEAN) ? win :
                     (q.c2[C2_LIMIT_BIT] && wtm != 5'h00) ? CNT_W'(wtm) : CNT_W'(DEPTH);
  assign full      = (q.count >= eff_depth);
  assign wtm_flag  = (wtm != 5'h00) && (q.count >= CNT_W'(wtm));
  assign shown     = (buffered && q.count != '0) ? q.mem[q.rd] : q.out;
  assign pop_read  = REG_RD && !REG_START && (q.ptr == ADDR_OUT_UPPER);
  assign cfg_write = REG_WR && !REG_START &&
                     (q.ptr == ADDR_BUFFER_CFG || q.ptr == ADDR_CONTROL_TWO);
  assign take      = stage_valid && stage_ready;
  // No sample is offered a slot before the trim copy ends
  assign SAMPLE_READY = stage_in_ready && q.trim_done;
  // Drain stalls while a host pop or a control two or buffer configuration write owns the buffer pointers
  assign stage_ready = !pop_read && !cfg_write;
  assign new_ext   = SUM_W'(signed'(stage_data));
  assign old_ext   = SUM_W'(signed'(q.mem[q.rd]));

  stage_fifo #(
    .W (SAMPLE_W),
    .D (STAGE_DEPTH)
  ) u_stage (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .ce        (CE),
    .in_valid  (SAMPLE_VALID && q.trim_done),
    .in_ready  (stage_in_ready),
    .in_data   (SAMPLE_DATA),
    .out_valid (stage_valid),
    .out_ready (stage_ready),
    .out_data  (stage_data)
  );

  always_comb
  begin
    s = q;
    // Trim copy, one word per cycle after reset
    if (!q.trim_done)
    begin
      s.trim[q.trim_idx] = NVM_DATA;
      s.trim_idx         = q.trim_idx + 2'h1;
      s.trim_done        = (q.trim_idx == 2'(TRIM_WORDS - 1));
    end
    if (!q.icfg[IC_LATCH_BIT])
      s.ia = 1'b0;
    if (REG_START)
    begin
      s.ptr = REG_ADDR;
      s.inc = REG_AUTO_INC;
    end
    else if (REG_RD)
    begin
      unique case (q.ptr)
        ADDR_CONTROL_TWO:  s.rdata = q.c2;
        ADDR_CONTROL_FOUR: s.rdata = q.c4;
        ADDR_INT_CONFIG:   s.rdata = q.icfg;
        ADDR_INT_SOURCE:   s.rdata = 8'(q.ia) << IS_ACTIVE_BIT;
        ADDR_OUT_LOWEST:   s.rdata = shown[7:0];
        ADDR_OUT_MIDDLE:   s.rdata = shown[15:8];
        ADDR_OUT_UPPER:    s.rdata = shown[23:16];
        ADDR_BUFFER_CFG:   s.rdata = q.bcfg;
        ADDR_BUFFER_STATE: s.rdata = {wtm_flag, q.ovr, q.count};
        default:           s.rdata = 8'h00;
      endcase
      if (q.ptr == ADDR_INT_SOURCE)
        s.ia = 1'b0;
      if (q.ptr == ADDR_BUFFER_STATE)
        s.ovr = 1'b0;
      if (pop_read)
      begin
        s.drdy = 1'b0;
        if (buffered && q.count != '0)
        begin
          s.out   = q.mem[q.rd];
          s.rd    = q.rd + 1'b1;
          s.count = q.count - 6'h01;
        end
      end
      if (q.inc)
        s.ptr = next_addr(q.ptr);
    end
    else if (REG_WR)
    begin
      unique case (q.ptr)
        ADDR_CONTROL_TWO:  s.c2   = REG_WDATA;
        ADDR_CONTROL_FOUR: s.c4   = REG_WDATA;
        ADDR_INT_CONFIG:   s.icfg = REG_WDATA;
        ADDR_BUFFER_CFG:   s.bcfg = REG_WDATA;
        default:           s.c2   = q.c2;
      endcase
      // New configuration restarts the buffer and re-arms the trigger
      if (cfg_write)
      begin
        s.count   = '0;
        s.rd      = '0;
        s.wr      = '0;
        s.sum     = '0;
        s.dec_cnt = '0;
        s.trig    = 1'b0;
      end
      if (q.inc)
        s.ptr = next_addr(q.ptr);
    end
    if (TRIGGER_EVENT)
      s.ia = 1'b1;
    if (q.ia)
      s.trig = 1'b1;
    if (take)
    begin
      s.drdy = 1'b1;
      unique case (beh)
        BEH_IDLE:
          s.out = stage_data;
        BEH_FILL:
        begin
          if (!full)
          begin
            s.mem[q.wr] = stage_data;
            s.wr        = q.wr + 1'b1;
            s.count     = q.count + 6'h01;
          end
          else
            s.ovr = 1'b1;
        end
        BEH_STREAM:
        begin
          s.mem[q.wr] = stage_data;
          s.wr        = q.wr + 1'b1;
          if (full)
          begin
            s.rd  = q.rd + 1'b1;
            s.ovr = 1'b1;
          end
          else
            s.count = q.count + 6'h01;
        end
        BEH_MEAN:
        begin
          s.mem[q.wr] = stage_data;
          s.wr        = q.wr + 1'b1;
          if (full)
          begin
            s.sum = q.sum + new_ext - old_ext;
            s.rd  = q.rd + 1'b1;
          end
          else
          begin
            s.sum   = q.sum + new_ext;
            s.count = q.count + 6'h01;
          end
          if (s.count == win)
          begin
            if (!q.c2[C2_DECIMATE_BIT] || q.dec_cnt == '0)
              s.out = SAMPLE_W'(s.sum >>> window_shift(wtm));
            if (q.c2[C2_DECIMATE_BIT])
              s.dec_cnt = (q.dec_cnt == '0) ?
                          rate_divider(SAMPLE_RATE) - 5'h01 : q.dec_cnt - 5'h01;
          end
          else
            s.out = stage_data;
        end
      endcase
    end
    if (beh == BEH_IDLE)
    begin
      s.count = '0;
      s.rd    = s.wr;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      q <= '0;
    else if (CE)
      q <= s;
  end

  genvar gi;
  generate
    for (gi = 0; gi < TRIM_WORDS; gi++)
    begin : g_trim
      assign TRIM_VALUE[8*gi +: 8] = q.trim[gi];
    end
  endgenerate

  assign NVM_ADDR            = q.trim_idx;
  assign TRIM_DONE           = q.trim_done;
  assign REG_RDATA           = q.rdata;
  assign DATA_READY          = q.drdy;
  assign INTERRUPT_READY_PIN = (q.c4[C4_DRDY_BIT] && q.drdy) ||
                               (q.c4[C4_OVR_BIT] && q.ovr) ||
                               (q.c4[C4_WTM_BIT] && wtm_flag) ||
                               (q.c4[C4_EMPTY_BIT] && q.count == '0);

  AST_DEPTH_BOUND: assert property (@(posedge CLK) disable iff (!ARST_N)
    cnt <= 6'h20) else $error("buffer count above depth");
  AST_BYPASS_EMPTY: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && beh == BEH_IDLE |=> cnt == '0) else $error("bypass left samples stored");
  AST_FILL_STOPS: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && take && beh == BEH_FILL && full |=> cnt == $past(cnt) && q.ovr)
    else $error("fill mode accepted past depth");
  AST_LIMIT_DEPTH: assert property (@(posedge CLK) disable iff (!ARST_N)
    buffered |-> cnt <= eff_depth) else $error("count beyond effective depth");
  AST_STREAM_DROPS: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && take && beh == BEH_STREAM && full |=> cnt == $past(cnt) && q.ovr)
    else $error("stream mode did not drop oldest");
  AST_POP_ON_UPPER: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && pop_read && buffered && cnt != '0 |=> cnt == $past(cnt) - 6'h01)
    else $error("read of upper byte did not pop");
  AST_ADDR_WRAP: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && pop_read && q.inc |=> q.ptr == ADDR_OUT_LOWEST)
    else $error("burst address did not wrap");
  AST_READY_SETS: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && take |=> DATA_READY) else $error("data ready missing after sample");
  AST_TRIM_FIRST: assert property (@(posedge CLK) disable iff (!ARST_N)
    !TRIM_DONE |-> !take ##0 !SAMPLE_READY) else $error("sample before trim load");
endmodule

// >>> host_model.sv
`timescale 1ns/1ns
module host_model
(
  input  wire logic       clk,
  output logic            reg_start,
  output logic [6:0]      reg_addr,
  output logic            reg_auto_inc,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_start    = 1'b0;
    reg_addr     = 7'h00;
    reg_auto_inc = 1'b0;
    reg_wr       = 1'b0;
    reg_wdata    = 8'h00;
    reg_rd       = 1'b0;
  end

  task automatic point(input logic [6:0] a, input logic inc);
    @(posedge clk);
    reg_start    <= 1'b1;
    reg_addr     <= a;
    reg_auto_inc <= inc;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    point(a, 1'b0);
    @(posedge clk);
    reg_start <= 1'b0;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Bytes land low first; n bytes end up in the top of w
  task automatic rd(input logic [6:0] a, input int n, output logic [47:0] w);
    point(a, n > 1);
    @(posedge clk);
    reg_start <= 1'b0;
    reg_rd    <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (i == n - 1)
        reg_rd <= 1'b0;
      @(negedge clk);
      w = {reg_rdata, w[47:8]};
    end
  endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb
  import pressure_fifo_pkg::*;
;
  typedef struct packed {
    logic [2:0] m;
    logic [7:0] c2;
    logic [4:0] wl;
    int         pre;
    logic       tg;
    int         post;
    logic [7:0] st;
    logic [7:0] mk;
    int         wi;
  } row_t;

  logic        clk, arst_n, sv, sr, trg, st, inc, wr, rd, trim_done, drdy, pin;
  logic [23:0] sd;
  logic [6:0]  ad;
  logic [7:0]  wd, rdat, nvm_d;
  logic [1:0]  nvm_a;
  logic [2:0]  rate;
  logic [31:0] trim_v;
  logic [47:0] w;
  logic [6:0]  regs [6] = '{7'h21, 7'h23, 7'h24, 7'h2E, 7'h2F, 7'h30};
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  row_t        rows [9] = '{
    '{3'h0, 8'h40, 5'h00, 0, 1'b0, 3, 8'h00, 8'hFF, 2},
    '{3'h1, 8'h40, 5'h00, 0, 1'b0, 34, 8'h60, 8'hFF, 0},
    '{3'h1, 8'h60, 5'h04, 0, 1'b0, 6, 8'h84, 8'hBF, 0},
    '{3'h2, 8'h40, 5'h00, 0, 1'b0, 34, 8'h20, 8'hBF, 2},
    '{3'h2, 8'h40, 5'h02, 0, 1'b0, 3, 8'h83, 8'hFF, 0},
    '{3'h3, 8'h40, 5'h00, 33, 1'b1, 2, 8'h60, 8'hFF, 1},
    '{3'h4, 8'h40, 5'h00, 2, 1'b1, 3, 8'h03, 8'hFF, 2},
    '{3'h7, 8'h40, 5'h00, 2, 1'b1, 3, 8'h03, 8'hFF, 2},
    '{3'h1, 8'h00, 5'h00, 0, 1'b0, 3, 8'h00, 8'hFF, 2}
  };

  assign nvm_d = 8'hA5 ^ {6'h00, nvm_a};

  pressure_sample_fifo pressure_sample_fifo_i (
    .CLK(clk), .ARST_N(arst_n), .CE(1'b1), .SAMPLE_VALID(sv), .SAMPLE_READY(sr),
    .SAMPLE_DATA(sd), .SAMPLE_RATE(rate), .TRIGGER_EVENT(trg), .REG_START(st),
    .REG_ADDR(ad), .REG_AUTO_INC(inc), .REG_WR(wr), .REG_WDATA(wd), .REG_RD(rd),
    .REG_RDATA(rdat), .NVM_ADDR(nvm_a), .NVM_DATA(nvm_d), .TRIM_DONE(trim_done),
    .TRIM_VALUE(trim_v), .DATA_READY(drdy), .INTERRUPT_READY_PIN(pin));

  host_model host_model_i (
    .clk(clk), .reg_start(st), .reg_addr(ad), .reg_auto_inc(inc), .reg_wr(wr),
    .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [23:0] smp(input int r, input int i);
    return {4'hF, r[3:0], 8'h5A, i[7:0]};
  endfunction

  task automatic send(input logic [23:0] d);
    logic r;
    @(posedge clk);
    sv <= 1'b1;
    sd <= d;
    do
    begin
      @(negedge clk);
      r = sr;
      @(posedge clk);
    end while (!r);
    sv <= 1'b0;
    sd <= ~d;
  endtask

  task automatic push(input int r, input int a, input int b);
    for (int i = a; i < b; i++)
      send(smp(r, i));
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test;
    end
  end

  initial
  begin
    arst_n = 1'b0;
    sv = 1'b0;
    sd = 24'h000000;
    trg = 1'b0;
    rate = RATE_25HZ;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(trim_done, 1'b1);
    check(trim_v, 32'hA6A7A4A5);
    host_model_i.wr(ADDR_BUFFER_STATE, 8'hFF);
    foreach (regs[k])
    begin
      host_model_i.rd(regs[k], 1, w);
      check(w[47:40], 8'h00);
    end
    host_model_i.wr(ADDR_CONTROL_FOUR, 8'h04);
    host_model_i.rd(ADDR_CONTROL_FOUR, 1, w);
    check(w[47:40], 8'h04);
    host_model_i.wr(ADDR_INT_CONFIG, 8'h04);
    foreach (rows[k])
    begin
      host_model_i.rd(ADDR_INT_SOURCE, 1, w);
      host_model_i.wr(ADDR_CONTROL_TWO, rows[k].c2);
      host_model_i.wr(ADDR_BUFFER_CFG, {rows[k].m, rows[k].wl});
      push(k, 0, rows[k].pre);
      if (rows[k].tg)
      begin
        @(posedge clk);
        trg <= 1'b1;
        repeat (2) @(posedge clk);
        trg <= 1'b0;
        repeat (2) @(posedge clk);
      end
      push(k, rows[k].pre, rows[k].pre + rows[k].post);
      repeat (3) @(posedge clk);
      check(drdy, 1'b1);
      check(pin, rows[k].st[7]);
      host_model_i.rd(ADDR_BUFFER_STATE, 1, w);
      check(w[47:40] & rows[k].mk, rows[k].st);
      host_model_i.rd(ADDR_OUT_LOWEST, 3, w);
      check(w[47:24], smp(k, rows[k].wi));
      check(drdy, 1'b0);
    end
    // Fill with a constant level whose newest sample lifts the mean by a fixed amount
    host_model_i.wr(ADDR_CONTROL_TWO, 8'h40);
    for (int wl = 1; wl < 32; wl = wl * 2 + 1)
    begin
      host_model_i.wr(ADDR_BUFFER_CFG, {MODE_MEAN, wl[4:0]});
      repeat (wl) send(24'h000100);
      send(24'h000100 + 24'((wl + 1) * 16));
      repeat (3) @(posedge clk);
      host_model_i.rd(ADDR_OUT_LOWEST, 3, w);
      check(w[47:24], 24'h000110);
    end
    host_model_i.wr(ADDR_BUFFER_CFG, {MODE_FILL, 5'h00});
    push(9, 0, 2);
    repeat (3) @(posedge clk);
    host_model_i.rd(ADDR_OUT_LOWEST, 6, w);
    check(w, {smp(9, 1), smp(9, 0)});
    // Drained buffer routes its empty state to the pin
    host_model_i.wr(ADDR_CONTROL_FOUR, 8'h08);
    @(negedge clk);
    check(pin, 1'b1);
    // Decimated mean holds its output for a whole divider period
    @(posedge clk);
    rate <= RATE_12HZ;
    host_model_i.wr(ADDR_CONTROL_TWO, 8'h50);
    host_model_i.wr(ADDR_BUFFER_CFG, {MODE_MEAN, 5'h01});
    repeat (2) send(24'h000100);
    repeat (DIV_12HZ - 1) send(24'h000200);
    repeat (3) @(posedge clk);
    host_model_i.rd(ADDR_OUT_LOWEST, 3, w);
    check(w[47:24], 24'h000100);
    send(24'h000200);
    repeat (3) @(posedge clk);
    host_model_i.rd(ADDR_OUT_LOWEST, 3, w);
    check(w[47:24], 24'h000200);
    // Reset in mid-run clears outputs and reloads trim
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    check({rdat, drdy, trim_done, sr, pin}, 12'h000);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(trim_done, 1'b1);
    check(trim_v, 32'hA6A7A4A5);
    host_model_i.rd(ADDR_BUFFER_CFG, 1, w);
    check(w[47:40], 8'h00);
    stop_test;
  end
endmodule
